// ### core/acsp_device.sv
// Converter control logic: channel power-down, test pattern, range and serial registers.
//
// Overview of operation
// - High I power-down floats both I buses
// - I power-down is pin OR register bit 11
// - Q power-down likewise via bit 10, independent
// - Receiver discards pipeline samples after power-up
// - Host recalibrates after channel power cycle
// - Test pattern drives all buses and flags
// - Range per channel via registers 3h, Bh
// - Select pin high holds registers at defaults
// - Each access is exactly 24 bits
// - Falling select starts a new access
// - Select rising before bit 24 aborts access
// - Long read holds last data bit out
// - Long write still commits at bit 24
// - Host releases select between accesses
// - Sample on rising, drive on falling edges
// - Output enabled only for read after command
// - Read data MSB first from 8th falling edge
// - Unimplemented address reads all zeros
// - First bit one reads, zero writes
// - Bits two and three are 10b
// - Bits 4-7 address, MSB first
// - Bit 8 ignored, bits 9-24 data MSB first
`timescale 1ns/100ps
`default_nettype none
module acsp_device
  import acsp_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // Serial link
  acsp_link_if.device      link,
  // Control pins
  input  wire logic        iChannelPowerdown,
  input  wire logic        qChannelPowerdown,
  input  wire logic        testPatternSelect,
  input  wire logic        fullScaleRangeSelect,
  input  wire logic        extendedControlSelectN,
  // Converter data
  input  wire logic [9:0]  iSample,
  input  wire logic [9:0]  qSample,
  input  wire logic        iOverRange,
  input  wire logic        qOverRange,
  // Output buses and enables (enable low means driven)
  output logic [9:0]       iOutputBus,
  output logic [9:0]       iDelayedOutputBus,
  output logic [9:0]       qOutputBus,
  output logic [9:0]       qDelayedOutputBus,
  output logic             iOutOfRangeFlag,
  output logic             qOutOfRangeFlag,
  output logic             iBusEnN,
  output logic             qBusEnN,
  output logic             iPoweredDown,
  output logic             qPoweredDown,
  output logic             extendedControlMode,
  output logic [15:0]      iRangeSetting,
  output logic [15:0]      qRangeSetting
);
  import acsp_pkg::*;

  logic [1:0]  selSync_q, clkSync_q, dinSync_q, pinSync0_q, pinSync1_q, pinSync2_q;
  logic [1:0]  ecSync_q, rangeSync_q;
  logic        clkPrev_q;
  logic [4:0]  bitCount_q;
  logic [7:0]  command_q;
  logic [15:0] dataIn_q;
  logic [15:0] shiftOut_q;
  logic        driveOut_q;
  logic [15:0] regFile_q [REG_COUNT];
  logic        selActive, riseEdge, fallEdge, isRead, extended_control_mode;
  logic        iPd, qPd, tp;

  // Two-flop synchronisers for every pin from outside the clock domain
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      selSync_q  <= 2'h3;
      clkSync_q  <= 2'h0;
      dinSync_q  <= 2'h0;
      pinSync0_q <= 2'h0;
      pinSync1_q <= 2'h0;
      pinSync2_q <= 2'h0;
      ecSync_q   <= 2'h3;
      rangeSync_q <= 2'h0;
      clkPrev_q  <= 1'b0;
    end else begin
      selSync_q  <= {selSync_q[0], link.selectN};
      clkSync_q  <= {clkSync_q[0], link.serialClk};
      dinSync_q  <= {dinSync_q[0], link.serialDataIn};
      pinSync0_q <= {pinSync0_q[0], iChannelPowerdown};
      pinSync1_q <= {pinSync1_q[0], qChannelPowerdown};
      pinSync2_q <= {pinSync2_q[0], testPatternSelect};
      ecSync_q   <= {ecSync_q[0], extendedControlSelectN};
      rangeSync_q <= {rangeSync_q[0], fullScaleRangeSelect};
      clkPrev_q  <= clkSync_q[1];
    end
  end

  assign selActive = !selSync_q[1];
  assign riseEdge  = clkSync_q[1] && !clkPrev_q;
  assign fallEdge  = !clkSync_q[1] && clkPrev_q;
  assign extended_control_mode       = !ecSync_q[1];
  // Only seven command bits are shifted in, so the direction sits one below the top
  assign isRead    = command_q[COMMAND_BITS - 2] == DIR_READ;

  // Bit counter; select high clears it so an early release aborts
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      bitCount_q <= 5'h00;
    end else if (!selActive || !extended_control_mode) begin
      bitCount_q <= 5'h00;
    end else if (riseEdge && bitCount_q < 5'(ACCESS_BITS)) begin
      bitCount_q <= bitCount_q + 5'h01;
    end
  end

  // Input shift: command bits then data bits, bit 8 dropped
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      command_q <= 8'h00;
      dataIn_q  <= 16'h0000;
    end else if (selActive && riseEdge && bitCount_q < 5'(ACCESS_BITS)) begin
      if (bitCount_q < 5'(COMMAND_BITS - 1)) begin
        command_q <= {command_q[6:0], dinSync_q[1]};
      end else if (bitCount_q >= 5'(COMMAND_BITS)) begin
        dataIn_q <= {dataIn_q[14:0], dinSync_q[1]};
      end
    end
  end

  // Default of one register; reset and the mode pin must restore the same values
  function automatic logic [15:0] regDefault(input int k);
    if (k == int'(I_RANGE_REG_ADDR) || k == int'(Q_RANGE_REG_ADDR)) begin
      return RANGE_RESET;
    end else if (k == int'(CONFIG_REG_ADDR)) begin
      return CONFIG_RESET;
    end
    return OTHER_RESET;
  endfunction : regDefault

  // Register file; non-extended mode holds every register at default
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int k = 0; k < REG_COUNT; k++) begin
        regFile_q[k] <= regDefault(k);
      end
    end else if (!extended_control_mode) begin
      for (int k = 0; k < REG_COUNT; k++) begin
        regFile_q[k] <= regDefault(k);
      end
    end else if (selActive && riseEdge && bitCount_q == 5'(ACCESS_BITS - 1)
                 && command_q[COMMAND_BITS - 2] == DIR_WRITE) begin
      // Commit on the 24th edge only; later edges do nothing
      regFile_q[command_q[3:0]] <= {dataIn_q[14:0], dinSync_q[1]};
    end
  end

  // Output shift: loads after the command, advances on falling edges
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      shiftOut_q <= 16'h0000;
      driveOut_q <= 1'b0;
    end else if (!selActive || !extended_control_mode) begin
      driveOut_q <= 1'b0;
    end else if (fallEdge && bitCount_q == 5'(COMMAND_BITS) && isRead) begin
      driveOut_q <= 1'b1;
      shiftOut_q <= IMPLEMENTED_MASK[command_q[3:0]] ? regFile_q[command_q[3:0]]
                                                      : 16'h0000;
    end else if (fallEdge && driveOut_q && bitCount_q < 5'(ACCESS_BITS)) begin
      shiftOut_q <= {shiftOut_q[14:0], 1'b0};
    end
    // Past bit 24 the last data bit simply stays put
  end

  // Link outputs come straight from flops
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      link.serialDataOut    <= 1'b0;
      link.serialDataOutEnN <= 1'b1;
    end else begin
      link.serialDataOut    <= shiftOut_q[15];
      link.serialDataOutEnN <= !driveOut_q;
    end
  end

  assign iPd = pinSync0_q[1] || (extended_control_mode && regFile_q[CONFIG_REG_ADDR][I_PD_BIT]);
  assign qPd = pinSync1_q[1] || (extended_control_mode && regFile_q[CONFIG_REG_ADDR][Q_PD_BIT]);
  assign tp  = extended_control_mode ? regFile_q[CONFIG_REG_ADDR][TEST_PATTERN_BIT] : pinSync2_q[1];

  // Output data path: test pattern replaces converter data and flags
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      iOutputBus        <= 10'h000;
      iDelayedOutputBus <= 10'h000;
      qOutputBus        <= 10'h000;
      qDelayedOutputBus <= 10'h000;
      iOutOfRangeFlag   <= 1'b0;
      qOutOfRangeFlag   <= 1'b0;
      iBusEnN           <= 1'b1;
      qBusEnN           <= 1'b1;
      iPoweredDown      <= 1'b0;
      qPoweredDown      <= 1'b0;
    end else begin
      iOutputBus        <= tp ? TEST_PATTERN_WORD : iSample;
      iDelayedOutputBus <= tp ? ~TEST_PATTERN_WORD : iOutputBus;
      qOutputBus        <= tp ? TEST_PATTERN_WORD : qSample;
      qDelayedOutputBus <= tp ? ~TEST_PATTERN_WORD : qOutputBus;
      iOutOfRangeFlag   <= tp ? 1'b1 : iOverRange;
      qOutOfRangeFlag   <= tp ? 1'b0 : qOverRange;
      iBusEnN           <= iPd;
      qBusEnN           <= qPd;
      iPoweredDown      <= iPd;
      qPoweredDown      <= qPd;
    end
  end

  // Mode and range settings; pin range applies to both channels outside extended mode
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      extendedControlMode <= 1'b0;
      iRangeSetting       <= RANGE_RESET;
      qRangeSetting       <= RANGE_RESET;
    end else begin
      extendedControlMode <= extended_control_mode;
      iRangeSetting <= extended_control_mode ? regFile_q[I_RANGE_REG_ADDR]
                           : {rangeSync_q[1], 15'h0000};
      qRangeSetting <= extended_control_mode ? regFile_q[Q_RANGE_REG_ADDR]
                           : {rangeSync_q[1], 15'h0000};
    end
  end
endmodule : acsp_device
`default_nettype wire

// ### core/acsp_host.sv
// Host serial master with Avalon-MM command and status registers.
`timescale 1ns/100ps
`default_nettype none
module acsp_host
  import acsp_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // Avalon-MM slave
  input  wire logic [3:0]  avsAddress,
  input  wire logic        avsRead,
  input  wire logic        avsWrite,
  input  wire logic [31:0] avsWriteData,
  output logic [31:0]      avsReadData,
  output logic             avsWaitRequest,
  // Serial link
  acsp_link_if.host        link
);
  import acsp_pkg::*;

  typedef enum {IDLE, LOW, HIGH, DONE} acsp_state_type;
  acsp_state_type state_q;
  logic [23:0] frame_q;
  logic [15:0] rdata_q, wdata_q;
  logic [4:0]  bits_q;
  logic [3:0]  div_q;
  logic        busy_q, isRead_q;
  logic [1:0]  sdoSync_q;
  logic        startReq;

  assign startReq = avsWrite && !avsWaitRequest && avsAddress == CTRL_ADDR
                    && avsWriteData[CTRL_START_BIT] && !busy_q;

  // Bus slave: one wait cycle, then answer
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      avsWaitRequest <= 1'b1;
      avsReadData    <= 32'h00000000;
      wdata_q        <= 16'h0000;
    end else begin
      avsWaitRequest <= !((avsRead || avsWrite) && avsWaitRequest);
      if (avsRead && avsWaitRequest) begin
        case (avsAddress)
          WDATA_ADDR:  avsReadData <= {16'h0000, wdata_q};
          RDATA_ADDR:  avsReadData <= {16'h0000, rdata_q};
          STATUS_ADDR: avsReadData <= {31'h00000000, busy_q};
          default:     avsReadData <= 32'h00000000;
        endcase
      end
      if (avsWrite && !avsWaitRequest && avsAddress == WDATA_ADDR) begin
        wdata_q <= avsWriteData[15:0];
      end
    end
  end

  // Serial engine: 24 bits, clock divided from clk, select toggled per access
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q           <= IDLE;
      frame_q           <= 24'h000000;
      bits_q            <= 5'h00;
      div_q             <= 4'h0;
      busy_q            <= 1'b0;
      isRead_q          <= 1'b0;
      rdata_q           <= 16'h0000;
      link.selectN      <= 1'b1;
      link.serialClk    <= 1'b0;
      link.serialDataIn <= 1'b0;
      sdoSync_q         <= 2'h0;
    end else begin
      sdoSync_q <= {sdoSync_q[0], link.serialDataOut};
      case (state_q)
        IDLE: begin
          if (startReq) begin
            frame_q  <= {avsWriteData[CTRL_READ_BIT], RESERVED_PATTERN,
                         avsWriteData[CTRL_ADDR_LSB +: ADDR_BITS], 1'b0, wdata_q};
            isRead_q <= avsWriteData[CTRL_READ_BIT];
            busy_q   <= 1'b1;
            bits_q   <= 5'h00;
            div_q    <= 4'h0;
            link.selectN <= 1'b0;
            state_q  <= LOW;
          end
        end
        LOW: begin
          div_q <= div_q + 4'h1;
          if (div_q == 4'h0) begin
            link.serialDataIn <= frame_q[23];
          end
          if (div_q == 4'(LINK_HALF_PERIOD - 1)) begin
            link.serialClk <= 1'b1;
            div_q   <= 4'h0;
            state_q <= HIGH;
          end
        end
        HIGH: begin
          div_q <= div_q + 4'h1;
          if (div_q == 4'(LINK_HALF_PERIOD - 1)) begin
            link.serialClk <= 1'b0;
            div_q   <= 4'h0;
            // Read data is captured late in the high phase, long after the falling drive
            if (isRead_q && bits_q >= 5'(COMMAND_BITS)) begin
              rdata_q <= {rdata_q[14:0], sdoSync_q[1]};
            end
            frame_q <= {frame_q[22:0], 1'b0};
            bits_q  <= bits_q + 5'h01;
            state_q <= (bits_q == 5'(ACCESS_BITS - 1)) ? DONE : LOW;
          end
        end
        DONE: begin
          div_q <= div_q + 4'h1;
          if (div_q == 4'(LINK_HALF_PERIOD - 1)) begin
            link.selectN <= 1'b1;
            busy_q  <= 1'b0;
            state_q <= IDLE;
          end
        end
        default: state_q <= IDLE;
      endcase
    end
  end
endmodule : acsp_host
`default_nettype wire

// ### core/acsp_link_if.sv
// Serial link between host controller and converter control port.
`timescale 1ns/100ps
`default_nettype none
interface acsp_link_if;
  logic selectN;
  logic serialClk;
  logic serialDataIn;
  logic serialDataOut;
  logic serialDataOutEnN;
  modport device (input selectN, input serialClk, input serialDataIn,
                  output serialDataOut, output serialDataOutEnN);
  modport host (output selectN, output serialClk, output serialDataIn,
                input serialDataOut, input serialDataOutEnN);
endinterface : acsp_link_if
`default_nettype wire

// ### core/acsp_pkg.sv
// Package with serial access layout, register map and timing constants.
package acsp_pkg;
  localparam int ACCESS_BITS       = 24;
  localparam int COMMAND_BITS      = 8;
  localparam int DATA_BITS         = 16;
  localparam int ADDR_BITS         = 4;
  localparam int REG_COUNT         = 16;
  localparam logic [1:0] RESERVED_PATTERN = 2'h2;
  localparam logic       DIR_READ  = 1'b1;
  localparam logic       DIR_WRITE = 1'b0;
  // Device register map
  localparam logic [3:0] CONFIG_REG_ADDR  = 4'h0;
  localparam logic [3:0] I_RANGE_REG_ADDR = 4'h3;
  localparam logic [3:0] Q_RANGE_REG_ADDR = 4'hB;
  localparam int I_PD_BIT          = 11;
  localparam int Q_PD_BIT          = 10;
  localparam int TEST_PATTERN_BIT  = 12;
  localparam logic [15:0] CONFIG_RESET   = 16'h0000;
  localparam logic [15:0] RANGE_RESET    = 16'h8000;
  localparam logic [15:0] OTHER_RESET    = 16'h0000;
  // Registers that hold no implemented storage read as zero
  localparam logic [15:0] IMPLEMENTED_MASK = 16'h080F;
  localparam logic [9:0]  TEST_PATTERN_WORD = 10'h2AA;
  // Link clock in the host: 200 MHz / 16 gives a 12.5 MHz serial clock
  localparam int LINK_HALF_PERIOD  = 8;
  // Controller register offsets on Avalon-MM
  localparam logic [3:0] CTRL_ADDR   = 4'h0;
  localparam logic [3:0] WDATA_ADDR  = 4'h4;
  localparam logic [3:0] RDATA_ADDR  = 4'h8;
  localparam logic [3:0] STATUS_ADDR = 4'hC;
  localparam int CTRL_START_BIT = 31;
  localparam int CTRL_READ_BIT  = 30;
  localparam int CTRL_ADDR_LSB  = 16;
endpackage : acsp_pkg

// ### verification/acsp_asserts.sv
// Assertions on the serial link between host and converter control port.
`timescale 1ns/100ps
`default_nettype none
module acsp_asserts (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Serial link
  input wire logic selectN,
  input wire logic serialClk,
  input wire logic serialDataIn,
  input wire logic serialDataOut,
  input wire logic serialDataOutEnN
);
  logic       clkPrev_q;
  logic       readBit_q;
  logic [4:0] edgeCnt_q;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // Rising link clock edges per access; the first bit is kept as direction
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      clkPrev_q <= 1'b0;
      edgeCnt_q <= 5'h00;
      readBit_q <= 1'b0;
    end else begin
      clkPrev_q <= serialClk;
      if (selectN) begin
        edgeCnt_q <= 5'h00;
      end else if (serialClk && !clkPrev_q && edgeCnt_q != 5'h1F) begin
        edgeCnt_q <= edgeCnt_q + 5'h01;
        if (edgeCnt_q == 5'h00) begin
          readBit_q <= serialDataIn;
        end
      end
    end
  end
  a_sdo_idle_float: assert property (selectN [*8] |-> serialDataOutEnN)
    else $error("serial output driven while deselected");
  a_sdo_release_bound: assert property ($rose(selectN) |-> ##[1:6] serialDataOutEnN)
    else $error("serial output not released after select");
  a_sdo_enable_cmd: assert property ($fell(serialDataOutEnN) |->
    edgeCnt_q == 5'h08 && readBit_q && !selectN)
    else $error("serial output enabled outside read data phase");
  a_sclk_idle_low: assert property (selectN |-> !serialClk)
    else $error("link clock not low between accesses");
  a_first_bit_ready: assert property ($fell(selectN) |-> !serialClk [*8])
    else $error("link clock rose too soon after select");
  a_sdi_stable_high: assert property (serialClk && $past(serialClk) |-> $stable(serialDataIn))
    else $error("serial input moved while clock high");
  a_sdo_stable_high: assert property (!serialDataOutEnN && serialClk && $past(serialClk)
    |-> $stable(serialDataOut))
    else $error("serial output moved while clock high");
  a_access_bit_count: assert property ($rose(selectN) |-> edgeCnt_q == 5'h18)
    else $error("access length not 24 clocks");
  a_sclk_high_width: assert property ($rose(serialClk) |-> serialClk [*8] ##1 !serialClk)
    else $error("link clock high phase wrong");
endmodule : acsp_asserts
`default_nettype wire

// ### verification/adc_control_serial_port_tb.sv
// Testbench joining host and converter control port over the serial link.
`timescale 1ns/100ps
`default_nettype none
module adc_control_serial_port_tb;
  import acsp_pkg::*;
  logic        clk, rst_b, iChannelPowerdown, qChannelPowerdown, testPatternSelect;
  logic        fullScaleRangeSelect, extendedControlSelectN, iOverRange, qOverRange;
  logic [9:0]  iSample, qSample, iOutputBus, iDelayedOutputBus, qOutputBus, qDelayedOutputBus;
  logic        iOutOfRangeFlag, qOutOfRangeFlag, iBusEnN, qBusEnN, iPoweredDown, qPoweredDown;
  logic        extendedControlMode, pd2, avsRead, avsWrite, avsWaitRequest;
  logic [15:0] iRangeSetting, qRangeSetting;
  logic [3:0]  avsAddress;
  logic [31:0] avsWriteData, avsReadData;
  int          nMismatch, comparisons;
  acsp_link_if link();
  acsp_link_if link2();
  acsp_host acsp_host_inst (.clk, .rst_b, .avsAddress, .avsRead, .avsWrite, .avsWriteData,
    .avsReadData, .avsWaitRequest, .link(link));
  acsp_device acsp_device_inst (.clk, .rst_b, .link(link), .iChannelPowerdown,
    .qChannelPowerdown, .testPatternSelect, .fullScaleRangeSelect, .extendedControlSelectN,
    .iSample, .qSample, .iOverRange, .qOverRange, .iOutputBus, .iDelayedOutputBus, .qOutputBus,
    .qDelayedOutputBus, .iOutOfRangeFlag, .qOutOfRangeFlag, .iBusEnN, .qBusEnN, .iPoweredDown,
    .qPoweredDown, .extendedControlMode, .iRangeSetting, .qRangeSetting);
  // Second port, driven bit by bit so accesses can be cut short or stretched
  acsp_device acsp_device_inst2 (.clk, .rst_b, .link(link2), .iChannelPowerdown,
    .qChannelPowerdown, .testPatternSelect, .fullScaleRangeSelect, .extendedControlSelectN,
    .iSample, .qSample, .iOverRange, .qOverRange, .iOutputBus(), .iDelayedOutputBus(),
    .qOutputBus(), .qDelayedOutputBus(), .iOutOfRangeFlag(), .qOutOfRangeFlag(), .iBusEnN(),
    .qBusEnN(), .iPoweredDown(pd2), .qPoweredDown(), .extendedControlMode(), .iRangeSetting(),
    .qRangeSetting());
  acsp_asserts acsp_asserts_inst (.clk, .rst_b, .selectN(link.selectN),
    .serialClk(link.serialClk), .serialDataIn(link.serialDataIn),
    .serialDataOut(link.serialDataOut), .serialDataOutEnN(link.serialDataOutEnN));
  // 200 MHz clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      nMismatch++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic end_sim;
    if (nMismatch == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : end_sim
  // Pins pass two sync flops and an output flop
  task automatic settle;
    repeat (6) @(posedge clk);
  endtask : settle
  // One Avalon transfer, held until waitrequest is seen low; only the watchdog ends a hang
  task automatic av(input logic rd, input logic [3:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    @(posedge clk);
    avsAddress <= a;
    avsRead <= rd;
    avsWrite <= !rd;
    avsWriteData <= d;
    do begin
      @(posedge clk);
    end while (avsWaitRequest !== 1'b0);
    q = avsReadData;
    avsRead <= 1'b0;
    avsWrite <= 1'b0;
  endtask : av
  // One serial register access run by the host, polled until idle
  task automatic reg_acc(input logic rd, input logic [3:0] a, input logic [15:0] d,
                         output logic [15:0] q);
    logic [31:0] s;
    av(1'b0, WDATA_ADDR, {16'h0000, d}, s);
    av(1'b0, CTRL_ADDR, {1'b1, rd, 10'h000, a, 16'h0000}, s);
    do begin
      av(1'b1, STATUS_ADDR, 32'h0000_0000, s);
    end while (s[0] !== 1'b0);
    av(1'b1, RDATA_ADDR, 32'h0000_0000, s);
    q = s[15:0];
  endtask : reg_acc
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    logic [15:0] q;
    reg_acc(DIR_WRITE, a, d, q);
  endtask : wr
  task automatic rd_chk(input string nm, input logic [3:0] a, input logic [15:0] e);
    logic [15:0] q;
    reg_acc(DIR_READ, a, 16'h0000, q);
    check(nm, q, e);
  endtask : rd_chk
  // Bit-banged access on the second link; bit 8 set to show it is ignored
  // Link clock of 13 system cycles, the nearest whole count to 64 ns
  task automatic bang(input logic rd, input logic [15:0] d, input int nClk,
                      output logic [15:0] q, output logic tail);
    logic [23:0] w;
    w = {rd, RESERVED_PATTERN, CONFIG_REG_ADDR, 1'b1, d};
    q = 16'h0000;
    tail = 1'b0;
    @(posedge clk);
    link2.selectN <= 1'b0;
    for (int i = 0; i < nClk; i++) begin
      link2.serialDataIn <= (i < 24) ? w[23 - i] : ~link2.serialDataIn;
      repeat (6) @(posedge clk);
      link2.serialClk <= 1'b1;
      // Read late in the high phase, well after the output moved on the fall
      repeat (7) @(posedge clk);
      if (i >= 8 && i < 24) q = {q[14:0], link2.serialDataOut};
      tail = link2.serialDataOut;
      link2.serialClk <= 1'b0;
    end
    repeat (7) @(posedge clk);
    link2.selectN <= 1'b1;
    repeat (13) @(posedge clk);
  endtask : bang
  task automatic t_pins;
    iChannelPowerdown <= 1'b1;
    fullScaleRangeSelect <= 1'b1;
    settle();
    check("i float", iBusEnN, 1'b1);
    check("q on", qBusEnN, 1'b0);
    check("ecm off", extendedControlMode, 1'b0);
    check("pin range", iRangeSetting, 16'h8000);
    iChannelPowerdown <= 1'b0;
    qChannelPowerdown <= 1'b1;
    fullScaleRangeSelect <= 1'b0;
    // The settle also flushes the samples left from before power-up
    settle();
    check("i on", iBusEnN, 1'b0);
    check("q float", qBusEnN, 1'b1);
    check("i data", iOutputBus, 10'h155);
    check("i delayed", iDelayedOutputBus, 10'h155);
    check("q data", qOutputBus, 10'h0F0);
    check("low range", qRangeSetting, 16'h0000);
    qChannelPowerdown <= 1'b0;
    testPatternSelect <= 1'b1;
    settle();
    check("pattern", iOutputBus, TEST_PATTERN_WORD);
    check("pattern d", iDelayedOutputBus, 10'(~TEST_PATTERN_WORD));
    check("q pattern", qOutputBus, TEST_PATTERN_WORD);
    check("q pattern d", qDelayedOutputBus, 10'(~TEST_PATTERN_WORD));
    check("i flag", iOutOfRangeFlag, 1'b1);
    check("q flag", qOutOfRangeFlag, 1'b0);
    testPatternSelect <= 1'b0;
  endtask : t_pins
  task automatic t_regs;
    logic [31:0] s;
    extendedControlSelectN <= 1'b0;
    settle();
    check("ecm on", extendedControlMode, 1'b1);
    wr(I_RANGE_REG_ADDR, 16'h1234);
    wr(Q_RANGE_REG_ADDR, 16'hABCD);
    rd_chk("reg 3h", I_RANGE_REG_ADDR, 16'h1234);
    rd_chk("reg Bh", Q_RANGE_REG_ADDR, 16'hABCD);
    check("i range", iRangeSetting, 16'h1234);
    check("q range", qRangeSetting, 16'hABCD);
    wr(4'h5, 16'hFFFF);
    rd_chk("reg 5h", 4'h5, 16'h0000);
    wr(CONFIG_REG_ADDR, 16'h0800);
    settle();
    check("i pd bit", iPoweredDown, 1'b1);
    check("q stays", qPoweredDown, 1'b0);
    qChannelPowerdown <= 1'b1;
    settle();
    check("q pd pin", qPoweredDown, 1'b1);
    qChannelPowerdown <= 1'b0;
    wr(CONFIG_REG_ADDR, 16'h1400);
    settle();
    check("i back on", iBusEnN, 1'b0);
    check("q pd bit", qBusEnN, 1'b1);
    check("reg pattern", iOutputBus, TEST_PATTERN_WORD);
    av(1'b1, 4'h2, 32'h0000_0000, s);
    check("unmapped", s, 32'h0000_0000);
  endtask : t_regs
  task automatic t_ecm;
    extendedControlSelectN <= 1'b1;
    settle();
    check("q pd cleared", qPoweredDown, 1'b0);
    extendedControlSelectN <= 1'b0;
    settle();
    rd_chk("reg 0h reset", CONFIG_REG_ADDR, CONFIG_RESET);
    rd_chk("reg 3h reset", I_RANGE_REG_ADDR, RANGE_RESET);
  endtask : t_ecm
  task automatic t_link2;
    logic [15:0] q;
    logic t;
    bang(DIR_WRITE, 16'h0801, 23, q, t);
    settle();
    check("short write", pd2, 1'b0);
    bang(DIR_WRITE, 16'h0801, 27, q, t);
    settle();
    check("long write", pd2, 1'b1);
    bang(DIR_READ, 16'h5A5A, 26, q, t);
    check("read data", q, 16'h0801);
    check("held bit", t, 1'b1);
    check("sdo off", link2.serialDataOutEnN, 1'b1);
  endtask : t_link2
  // Watchdog well beyond the expected run
  initial begin
    #200000;
    nMismatch++;
    end_sim();
  end
  // Main sequence
  initial begin
    {rst_b, iChannelPowerdown, qChannelPowerdown, testPatternSelect} = 4'h0;
    {fullScaleRangeSelect, iOverRange, avsRead, avsWrite} = 4'h0;
    {extendedControlSelectN, qOverRange, link2.selectN} = 3'h7;
    {link2.serialClk, link2.serialDataIn} = 2'h0;
    iSample = 10'h155;
    qSample = 10'h0F0;
    avsAddress = 4'h0;
    avsWriteData = 32'h0000_0000;
    nMismatch = 0;
    comparisons = 0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    t_pins();
    t_regs();
    t_ecm();
    t_link2();
    end_sim();
  end
endmodule : adc_control_serial_port_tb
`default_nettype wire
